// ### core/dcap_pkg.sv
// Constants and carrier types for the device capability register.
// Assumes a dword-aligned configuration access port on the link-side clock.
package dcap_pkg;

    localparam int unsigned DCAP_DATA_W        = 32;
    localparam logic [11:0] DCAP_OFFSET        = 12'h048;
    localparam logic [31:0] DCAP_RESET_VALUE   = 32'h00000001;

    localparam int unsigned DCAP_SCALE_HI      = 27;
    localparam int unsigned DCAP_SCALE_LO      = 26;
    localparam int unsigned DCAP_VALUE_HI      = 25;
    localparam int unsigned DCAP_VALUE_LO      = 18;
    localparam int unsigned DCAP_L1_LAT_HI     = 11;
    localparam int unsigned DCAP_L1_LAT_LO     = 9;
    localparam int unsigned DCAP_L0S_LAT_HI    = 8;
    localparam int unsigned DCAP_L0S_LAT_LO    = 6;
    localparam int unsigned DCAP_EXT_TAG_BIT   = 5;
    localparam int unsigned DCAP_PHANTOM_HI    = 4;
    localparam int unsigned DCAP_PHANTOM_LO    = 3;
    localparam int unsigned DCAP_PAYLOAD_HI    = 2;
    localparam int unsigned DCAP_PAYLOAD_LO    = 0;

    localparam logic [1:0] DCAP_SCALE_RESET    = 2'h0;
    localparam logic [7:0] DCAP_VALUE_RESET    = 8'h00;
    localparam logic [2:0] DCAP_L1_LATENCY     = 3'h0;
    localparam logic [2:0] DCAP_L0S_LATENCY    = 3'h0;
    localparam logic       DCAP_EXT_TAG        = 1'h0;
    localparam logic [1:0] DCAP_PHANTOM        = 2'h0;
    localparam logic [2:0] DCAP_MAX_PAYLOAD    = 3'h1;

    // Scale encodings: 1.0x, 0.1x, 0.01x, 0.001x
    localparam logic [1:0] DCAP_SCALE_X1       = 2'h0;
    localparam logic [1:0] DCAP_SCALE_X0P1     = 2'h1;
    localparam logic [1:0] DCAP_SCALE_X0P01    = 2'h2;
    localparam logic [1:0] DCAP_SCALE_X0P001   = 2'h3;

    typedef struct packed {
        logic [1:0] scale;
        logic [7:0] value;
    } dcap_spl_msg_t;

    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic [1:0] captured_power_scale;
        logic [7:0] captured_power_value;
        logic [5:0] rsvd_mid;
        logic [2:0] l1_accept_latency;
        logic [2:0] l0s_accept_latency;
        logic       extended_tag_support;
        logic [1:0] phantom_function_support;
        logic [2:0] max_payload_support;
    } dcap_word_t;

endpackage : dcap_pkg

// ### core/dcap_device_capability.sv
// Device capability register with captured slot power limit fields.
// Assumes the link core delivers decoded slot power limit messages and
// configuration accesses synchronously on CLK_I.
`timescale 1ns/1ps
module dcap_device_capability
    import dcap_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
)
(
    input  wire logic                   CLK_I,
    input  wire logic                   RST_N_I,
    input  wire logic                   CE_I,
    input  wire logic                   SPL_VALID_I,
    input  wire dcap_spl_msg_t          SPL_MSG_I,
    input  wire logic                   CFG_RD_I,
    input  wire logic                   CFG_WR_I,
    input  wire logic [ADDR_W-1:0]      CFG_ADDR_I,
    output logic                        CFG_ACK_O,
    output logic [DCAP_DATA_W-1:0]      CFG_RDATA_O
);

    if (ADDR_W < 8 || ADDR_W > 12)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 8 and 12");
    end

    logic [1:0]             scale_reg;
    logic [1:0]             scale_next;
    logic [7:0]             value_reg;
    logic [7:0]             value_next;
    logic                   ack_reg;
    logic                   ack_next;
    logic [DCAP_DATA_W-1:0] rdata_reg;
    logic [DCAP_DATA_W-1:0] rdata_next;
    logic                   hit;
    dcap_word_t             cap_word;

    // Only dword address bits are compared; byte lanes inside the dword are not used
    assign hit = (CFG_ADDR_I[ADDR_W-1:2] == DCAP_OFFSET[ADDR_W-1:2]);

    // Fixed fields come from package constants, so a changed capability is a one-line edit there
    always_comb
    begin
        cap_word                          = '0;
        cap_word.captured_power_scale     = scale_reg;
        cap_word.captured_power_value     = value_reg;
        cap_word.l1_accept_latency        = DCAP_L1_LATENCY;
        cap_word.l0s_accept_latency       = DCAP_L0S_LATENCY;
        cap_word.extended_tag_support     = DCAP_EXT_TAG;
        cap_word.phantom_function_support = DCAP_PHANTOM;
        cap_word.max_payload_support      = DCAP_MAX_PAYLOAD;
    end

    // Captured power limit; a write access never reaches these flops
    always_comb
    begin
        scale_next = scale_reg;
        value_next = value_reg;
        if (CE_I && SPL_VALID_I)
        begin
            scale_next = SPL_MSG_I.scale;
            value_next = SPL_MSG_I.value;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            scale_reg <= DCAP_SCALE_RESET;
            value_reg <= DCAP_VALUE_RESET;
        end
        else
        begin
            scale_reg <= scale_next;
            value_reg <= value_next;
        end
    end

    // Read port: one-cycle ack for any read or write hit; writes are acked and dropped
    always_comb
    begin
        ack_next   = ack_reg;
        rdata_next = rdata_reg;
        if (CE_I)
        begin
            ack_next = hit && (CFG_RD_I || CFG_WR_I);
            if (hit && CFG_RD_I)
            begin
                rdata_next = cap_word;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ack_reg   <= 1'h0;
            rdata_reg <= '0;
        end
        else
        begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign CFG_ACK_O   = ack_reg;
    assign CFG_RDATA_O = rdata_reg;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence s_read_hit;
        CE_I && CFG_RD_I && hit;
    endsequence

    sequence s_spl_load;
        CE_I && SPL_VALID_I;
    endsequence

    sequence s_write_hit;
        CE_I && CFG_WR_I && hit;
    endsequence

    sequence s_idle;
        CE_I && !CFG_RD_I && !CFG_WR_I;
    endsequence

    chk_read_ack_data: assert property (
        s_read_hit |=> CFG_ACK_O && CFG_RDATA_O == $past(cap_word))
        else $error("Read hit not answered with register word next cycle");

    chk_miss_no_ack: assert property (
        CE_I && !hit |=> !CFG_ACK_O)
        else $error("Acknowledge given for an address outside this register");

    chk_scale_capture: assert property (
        s_spl_load ##1 (!SPL_VALID_I || !CE_I)[*2] |->
            scale_reg == $past(SPL_MSG_I.scale, 2))
        else $error("Captured power scale lost the message scale");

    chk_value_capture: assert property (
        s_spl_load ##1 s_read_hit |=>
            CFG_RDATA_O[DCAP_VALUE_HI:DCAP_VALUE_LO] == $past(SPL_MSG_I.value, 2))
        else $error("Captured power value not seen on the following read");

    chk_scale_field: assert property (
        s_read_hit |=> CFG_RDATA_O[DCAP_SCALE_HI:DCAP_SCALE_LO] == $past(scale_reg))
        else $error("Scale field misplaced in read data");

    chk_fixed_zero: assert property (
        CFG_ACK_O |-> CFG_RDATA_O[DCAP_L1_LAT_HI:DCAP_L1_LAT_LO] == 3'h0
            && CFG_RDATA_O[DCAP_L0S_LAT_HI:DCAP_L0S_LAT_LO] == 3'h0)
        else $error("Latency fields not zero");

    chk_tag_phantom: assert property (
        CFG_ACK_O |-> !CFG_RDATA_O[DCAP_EXT_TAG_BIT]
            && CFG_RDATA_O[DCAP_PHANTOM_HI:DCAP_PHANTOM_LO] == 2'h0)
        else $error("Tag or phantom field not zero");

    chk_payload_field: assert property (
        s_read_hit |=> CFG_RDATA_O[DCAP_PAYLOAD_HI:DCAP_PAYLOAD_LO] == 3'h1)
        else $error("Max payload field not 001b");

    chk_reserved_zero: assert property (
        CFG_ACK_O |-> CFG_RDATA_O[31:28] == 4'h0 && CFG_RDATA_O[17:12] == 6'h00)
        else $error("Reserved bits not zero");

    chk_write_ignored: assert property (
        CE_I && CFG_WR_I && !SPL_VALID_I |=> $stable(scale_reg) && $stable(value_reg))
        else $error("Configuration write changed captured fields");

    chk_freeze_ce: assert property (
        !CE_I |=> $stable(CFG_ACK_O) && $stable(CFG_RDATA_O) && $stable(value_reg))
        else $error("State moved while clock enable low");

    chk_write_ack: assert property (
        s_write_hit |=> CFG_ACK_O)
        else $error("Write hit not acknowledged");

    chk_idle_no_ack: assert property (
        s_idle |=> !CFG_ACK_O)
        else $error("Acknowledge given with no request");

    // Read data may only move on a read hit, so a miss or a write cannot leak other state
    chk_rdata_hold: assert property (
        !(CE_I && CFG_RD_I && hit) |=> $stable(CFG_RDATA_O))
        else $error("Read data changed without a read hit");

    // Read and write in one cycle behave as a read
    chk_rdwr_read: assert property (
        CE_I && CFG_RD_I && CFG_WR_I && hit |=> CFG_ACK_O && CFG_RDATA_O == $past(cap_word))
        else $error("Combined read and write not answered as a read");

    chk_spl_load: assert property (
        s_spl_load |=> scale_reg == $past(SPL_MSG_I.scale)
            && value_reg == $past(SPL_MSG_I.value))
        else $error("Message fields not captured on the next edge");

    // Junk on the message bus between pulses must never reach the fields
    chk_fields_hold: assert property (
        !(CE_I && SPL_VALID_I) |=> $stable(scale_reg) && $stable(value_reg))
        else $error("Captured fields moved without a message");

    chk_freeze_fields: assert property (
        !CE_I |=> $stable(scale_reg))
        else $error("Captured scale moved while clock enable low");

endmodule : dcap_device_capability

// ### sim/dcap_link_model.sv
// Link-side model that delivers decoded slot power limit messages.
// Assumes the bench calls send_spl from its main sequence.
`timescale 1ns/1ps
module dcap_link_model
    import dcap_pkg::*;
(
    input  wire logic    clk_i,
    output logic          spl_valid_o,
    output dcap_spl_msg_t spl_msg_o
);
    initial
    begin
        spl_valid_o = 1'h0;
        spl_msg_o   = '0;
    end

    task automatic send_spl(input logic [1:0] scale, input logic [7:0] value);
        @(posedge clk_i);
        #1;
        spl_valid_o = 1'h1;
        spl_msg_o   = {scale, value};
        @(posedge clk_i);
        #1;
        spl_valid_o = 1'h0;
        // Payload is junk between messages so a held copy cannot hide a bug
        spl_msg_o   = ~spl_msg_o;
    endtask : send_spl
endmodule : dcap_link_model

// ### sim/tb_pcie_device_capability_reg.sv
// Self-checking bench for the device capability register.
// Assumes a hit is acked one edge after it is taken.
`timescale 1ns/1ps
module tb_pcie_device_capability_reg
    import dcap_pkg::*;
;
    logic          clk, rst_n, ce, rd, wr, spl_valid, ack;
    logic [11:0]   addr;
    logic [31:0]   rdata, word;
    dcap_spl_msg_t spl_msg;
    int            miscompares, tests_run;

    dcap_device_capability #(.ADDR_W(12)) u_dcap_device_capability (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .SPL_VALID_I(spl_valid), .SPL_MSG_I(spl_msg), .CFG_RD_I(rd), .CFG_WR_I(wr), .CFG_ADDR_I(addr),
        .CFG_ACK_O(ack), .CFG_RDATA_O(rdata));
    dcap_link_model u_dcap_link_model (.clk_i(clk), .spl_valid_o(spl_valid), .spl_msg_o(spl_msg));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Slot power bound in milliwatts, as software derives it from the captured fields
    function automatic logic [31:0] power_mw(input logic [31:0] w);
        logic [31:0] step;
        case (w[27:26])
            2'h0: step = 32'h000003E8;
            2'h1: step = 32'h00000064;
            2'h2: step = 32'h0000000A;
            default: step = 32'h00000001;
        endcase
        power_mw = w[25:18] * step;
    endfunction : power_mw

    task automatic cfg(input logic r, input logic w, input logic [11:0] a, input logic hit, input logic [31:0] d);
        @(posedge clk);
        #1;
        rd   = r;
        wr   = w;
        addr = a;
        @(posedge clk);
        #1;
        rd = 1'h0;
        wr = 1'h0;
        check("ack", {31'h0, hit}, {31'h0, ack});
        check("rdata", d, rdata);
    endtask : cfg

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        // About 50 cycles expected; the margin covers slow acks
        repeat (3000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial
    begin
        rst_n = 1'h0;
        ce    = 1'h1;
        rd    = 1'h0;
        wr    = 1'h0;
        addr  = 12'h000;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'h1;
        cfg(1'h1, 1'h0, 12'h048, 1'h1, 32'h00000001);
        $display("test reset_value done");
        for (int s = 0; s < 4; s++)
        begin
            u_dcap_link_model.send_spl(s[1:0], 8'hA5 ^ s[7:0]);
            word = {4'h0, s[1:0], 8'hA5 ^ s[7:0], 6'h00, 9'h000, 3'h1};
            cfg(1'h1, 1'h0, 12'h04B, 1'h1, word);
        end
        $display("test capture done");
        cfg(1'h0, 1'h1, 12'h048, 1'h1, word);
        cfg(1'h1, 1'h1, 12'h04A, 1'h1, word);
        cfg(1'h1, 1'h0, 12'h04C, 1'h0, word);
        cfg(1'h1, 1'h0, 12'h044, 1'h0, word);
        ce = 1'h0;
        u_dcap_link_model.send_spl(2'h0, 8'h00);
        cfg(1'h1, 1'h0, 12'h048, 1'h0, word);
        ce = 1'h1;
        cfg(1'h1, 1'h0, 12'h048, 1'h1, word);
        $display("test access done");
        fork
            u_dcap_link_model.send_spl(2'h1, 8'h19);
            cfg(1'h1, 1'h0, 12'h048, 1'h1, word);
        join
        cfg(1'h1, 1'h0, 12'h048, 1'h1, 32'h04640001);
        check("power_mw", 32'h000009C4, power_mw(rdata));
        // Read taken on the edge right after the message edge sees the new fields
        fork
            u_dcap_link_model.send_spl(2'h2, 8'h3C);
            begin
                @(posedge clk);
                cfg(1'h1, 1'h0, 12'h048, 1'h1, 32'h08F00001);
            end
        join
        check("power_mw", 32'h00000258, power_mw(rdata));
        rst_n = 1'h0;
        #10;
        check("rdata", 32'h00000000, rdata);
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'h1;
        cfg(1'h1, 1'h0, 12'h048, 1'h1, 32'h00000001);
        $display("test message_order done");
        complete_run();
    end
endmodule : tb_pcie_device_capability_reg
